// ### inc/dpi2c_pkg.sv
`default_nettype none
package dpi2c_pkg;
    localparam logic [3:0] ADDR_PREFIX   = 4'h5;
    localparam logic [7:0] CFG_RESET     = 8'h87;
    localparam logic [7:0] WIPER_RESET   = 8'h3F;
    localparam int         CFG_VOL_BIT   = 2;
    localparam int         CFG_ZC_BIT    = 1;
    localparam logic [1:0] SEL_WIPER0    = 2'h0;
    localparam logic [1:0] SEL_WIPER1    = 2'h1;
    localparam logic [1:0] SEL_CFG       = 2'h2;
    localparam int         CLK_MHZ       = 200;
    localparam int         NV_COMMIT_TIME_US = 10;
    localparam int         NV_COMMIT_CYC = NV_COMMIT_TIME_US * CLK_MHZ;
    localparam logic [1:0] RD_IDX_LAST   = 2'h2;

    typedef enum logic [5:0]
    {
        DPI_IDLE  = 6'h01,
        DPI_ADDR  = 6'h02,
        DPI_AACK  = 6'h04,
        DPI_WDATA = 6'h08,
        DPI_RDATA = 6'h10,
        DPI_RACK  = 6'h20
    } dpi_state_e;

    typedef struct packed
    {
        logic [7:0] wiper0;
        logic [7:0] wiper1;
        logic [7:0] cfg;
    } dpi_regs_s;
endpackage
`default_nettype wire

// ### rtl/dpi_sync2.sv
`default_nettype none
module dpi_sync2
(
    input  wire logic mclk,
    input  wire logic arst_n,
    input  wire logic d,
    output var  logic q
);
    logic meta_ff;
    logic q_ff;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_ff <= 1'b1;
            q_ff    <= 1'b1;
        end
        else
        begin
            meta_ff <= d;
            q_ff    <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule
`default_nettype wire

// ### rtl/dpi2c_slave.sv
`default_nettype none
// Operation
// - Device is bus slave only; master makes clock, START and STOP.
// - SDA falling while SCL high is START, beginning a transfer.
// - SDA rising while SCL high is STOP, ending the transfer.
// - Repeated START acts like START and restarts address decoding.
// - Data changes while SCL low; device samples on SCL rising edge.
// - Device drives each read bit at the preceding SCL falling edge.
// - Ninth bit is acknowledge: zero acknowledges, one does not.
// - Bytes are eight bits MSB first plus acknowledge; device acks writes.
// - Master nacks final read byte; device then releases SDA.
// - Respond only when address equals 0101 plus three strap pins.
// - Address LSB zero means write, one means read.
// - Wrong address: no acknowledge, ignore bus until next START.
// - Write transaction accepts any number of data bytes.
// - After committing STOP, refuse own address until write time elapses.
// - Every commit rewrites both wipers and configuration.
// - With zero-crossing on, commit waits for zero-crossing to finish.
// - Read always starts with wiper 0.
// - Read order is wiper 0, wiper 1, configuration.
// - Acked configuration byte wraps to wiper 0, cycling on.
// - Serial lines honoured only while comm enable low.
// - Top bits 00, 01, 10 select wiper 0, wiper 1, configuration.
// - Nonvolatile STOP after a written byte triggers commit; volatile STOP commits nothing.
module dpi2c_slave
#(
    parameter int NV_CYCLES = dpi2c_pkg::NV_COMMIT_CYC
)
(
    input  wire logic                 mclk,
    input  wire logic                 arst_n,
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    output var  logic                 sda_o,
    output var  logic                 sda_oe,
    input  wire logic                 comm_en_n,
    input  wire logic                 addr_strap_bit0,
    input  wire logic                 addr_strap_bit1,
    input  wire logic                 addr_strap_bit2,
    input  wire logic                 zc_done,
    output var  dpi2c_pkg::dpi_regs_s regs,
    output var  logic                 nv_write,
    output var  logic                 nv_busy
);
    logic                  scl_s;
    logic                  sda_s;
    logic                  cen_s;
    logic                  strap0_s;
    logic                  strap1_s;
    logic                  strap2_s;
    logic                  zc_s;
    logic                  scl_d_ff;
    logic                  sda_d_ff;
    dpi2c_pkg::dpi_state_e state_ff;
    dpi2c_pkg::dpi_state_e nxt_state;
    logic [7:0]            shift_ff;
    logic [3:0]            bit_ff;
    logic                  sda_oe_ff;
    logic                  dirty_ff;
    logic                  pend_ff;
    logic                  busy_ff;
    logic                  nvw_ff;
    logic [31:0]           cnt_ff;
    logic [1:0]            rd_idx_ff;
    dpi2c_pkg::dpi_regs_s  regs_ff;

    dpi_sync2 u_scl (.mclk(mclk), .arst_n(arst_n), .d(scl_i), .q(scl_s));
    dpi_sync2 u_sda (.mclk(mclk), .arst_n(arst_n), .d(sda_i), .q(sda_s));
    dpi_sync2 u_cen (.mclk(mclk), .arst_n(arst_n), .d(comm_en_n), .q(cen_s));
    // Straps are static, but still synced so no pin reaches logic raw
    dpi_sync2 u_st0 (.mclk(mclk), .arst_n(arst_n), .d(addr_strap_bit0), .q(strap0_s));
    dpi_sync2 u_st1 (.mclk(mclk), .arst_n(arst_n), .d(addr_strap_bit1), .q(strap1_s));
    dpi_sync2 u_st2 (.mclk(mclk), .arst_n(arst_n), .d(addr_strap_bit2), .q(strap2_s));
    dpi_sync2 u_zcd (.mclk(mclk), .arst_n(arst_n), .d(zc_done), .q(zc_s));

    // Edge and condition decode; the device never drives SCL
    wire        en       = !cen_s;
    wire        scl_rise = en && scl_s && !scl_d_ff;
    wire        scl_fall = en && !scl_s && scl_d_ff;
    wire        start_c  = en && scl_s && scl_d_ff && sda_d_ff && !sda_s;
    wire        stop_c   = en && scl_s && scl_d_ff && !sda_d_ff && sda_s;
    wire [7:0]  rx_byte  = {shift_ff[6:0], sda_s};
    wire [6:0]  my_addr  = {dpi2c_pkg::ADDR_PREFIX, strap2_s, strap1_s, strap0_s};
    wire        addr_hit = (rx_byte[7:1] == my_addr) && !busy_ff;
    wire        last_bit = (bit_ff == 4'h7);
    wire        cfg_vol  = regs_ff.cfg[dpi2c_pkg::CFG_VOL_BIT];
    wire        cfg_zc   = regs_ff.cfg[dpi2c_pkg::CFG_ZC_BIT];
    wire [7:0]  rd_byte  = (rd_idx_ff == 2'h0) ? regs_ff.wiper0 :
                           (rd_idx_ff == 2'h1) ? regs_ff.wiper1 : regs_ff.cfg;
    wire [1:0]  rd_next  = (rd_idx_ff == dpi2c_pkg::RD_IDX_LAST) ? 2'h0 : rd_idx_ff + 2'h1;
    wire        wr_done  = (state_ff == dpi2c_pkg::DPI_WDATA) && scl_rise && last_bit;
    wire        rack_in  = (state_ff == dpi2c_pkg::DPI_RACK) && scl_rise;
    wire        commit   = stop_c && dirty_ff && !cfg_vol;
    wire        zc_ok    = !cfg_zc || zc_s;

    // Bit-level state machine
    always_comb
    begin
        nxt_state = state_ff;
        if (start_c)
            nxt_state = dpi2c_pkg::DPI_ADDR;
        else if (stop_c || !en)
            nxt_state = dpi2c_pkg::DPI_IDLE;
        else
        begin
            case (state_ff)
                dpi2c_pkg::DPI_ADDR:
                    if (scl_rise && last_bit)
                        nxt_state = addr_hit ? dpi2c_pkg::DPI_AACK : dpi2c_pkg::DPI_IDLE;
                dpi2c_pkg::DPI_AACK:
                    if (scl_fall && sda_oe_ff)
                        nxt_state = shift_ff[0] ? dpi2c_pkg::DPI_RDATA : dpi2c_pkg::DPI_WDATA;
                dpi2c_pkg::DPI_WDATA:
                    if (scl_fall && bit_ff == 4'h8)
                        nxt_state = dpi2c_pkg::DPI_WDATA;
                dpi2c_pkg::DPI_RDATA:
                    if (scl_fall && bit_ff == 4'h8)
                        nxt_state = dpi2c_pkg::DPI_RACK;
                dpi2c_pkg::DPI_RACK:
                    if (scl_rise)
                        nxt_state = sda_s ? dpi2c_pkg::DPI_IDLE : dpi2c_pkg::DPI_RDATA;
                default:
                    nxt_state = state_ff;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            state_ff <= dpi2c_pkg::DPI_IDLE;
        end
        else
        begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
            state_ff <= nxt_state;
        end
    end

    // Bit counter and shifter; ninth slot is counted as bit 8
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bit_ff   <= 4'h0;
            shift_ff <= 8'h00;
        end
        else if (start_c || stop_c)
        begin
            bit_ff   <= 4'h0;
            shift_ff <= 8'h00;
        end
        else if (scl_rise && state_ff != dpi2c_pkg::DPI_IDLE)
        begin
            bit_ff   <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
            shift_ff <= (bit_ff == 4'h8) ? shift_ff : rx_byte;
        end
        else if (scl_fall && bit_ff == 4'h0 && state_ff == dpi2c_pkg::DPI_AACK)
        begin
            bit_ff   <= 4'h0;
        end
    end

    // SDA drive: ack slot and read data slots only, changed on SCL falling edges
    wire rd_slot   = (state_ff == dpi2c_pkg::DPI_RDATA) ||
                     ((state_ff == dpi2c_pkg::DPI_AACK) && shift_ff[0]);
    wire [2:0] tx_pos = (state_ff == dpi2c_pkg::DPI_RDATA) ? 3'(7 - bit_ff) : 3'h7;
    logic tx_bit_ff;
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sda_oe_ff <= 1'b0;
            tx_bit_ff <= 1'b1;
        end
        else if (start_c || stop_c || !en)
        begin
            sda_oe_ff <= 1'b0;
            tx_bit_ff <= 1'b1;
        end
        else if (scl_fall)
        begin
            if (state_ff == dpi2c_pkg::DPI_AACK && bit_ff == 4'h8)
            begin
                sda_oe_ff <= 1'b1;                                  // address ack
                tx_bit_ff <= 1'b0;
            end
            else if (state_ff == dpi2c_pkg::DPI_WDATA && bit_ff == 4'h8)
            begin
                sda_oe_ff <= 1'b1;                                  // data ack
                tx_bit_ff <= 1'b0;
            end
            else if (rd_slot && bit_ff < 4'h8 && !(state_ff == dpi2c_pkg::DPI_AACK && !sda_oe_ff))
            begin
                // Drive only zeros; a one is released like an open drain
                sda_oe_ff <= !rd_byte[tx_pos];
                tx_bit_ff <= 1'b0;
            end
            else
            begin
                sda_oe_ff <= 1'b0;
                tx_bit_ff <= 1'b1;
            end
        end
    end

    // Read pointer always restarts at wiper 0 on a new transfer
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            rd_idx_ff <= 2'h0;
        else if (start_c)
            rd_idx_ff <= 2'h0;
        else if (rack_in && !sda_s)
            rd_idx_ff <= rd_next;
    end

    // Register writes only after a full byte; partial bytes never land
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            regs_ff  <= '{wiper0: dpi2c_pkg::WIPER_RESET, wiper1: dpi2c_pkg::WIPER_RESET,
                          cfg: dpi2c_pkg::CFG_RESET};
            dirty_ff <= 1'b0;
        end
        else if (wr_done && !start_c && !stop_c)
        begin
            dirty_ff <= 1'b1;
            if (rx_byte[7:6] == dpi2c_pkg::SEL_WIPER0)
                regs_ff.wiper0 <= {2'h0, rx_byte[5:0]};
            else if (rx_byte[7:6] == dpi2c_pkg::SEL_WIPER1)
                regs_ff.wiper1 <= {2'h0, rx_byte[5:0]};
            else if (rx_byte[7:6] == dpi2c_pkg::SEL_CFG)
                regs_ff.cfg    <= rx_byte;
        end
        else if (stop_c)
            dirty_ff <= 1'b0;
    end

    // Nonvolatile commit: pend for zero crossing, then count write time
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pend_ff <= 1'b0;
            busy_ff <= 1'b0;
            nvw_ff  <= 1'b0;
            cnt_ff  <= 32'h0;
        end
        else
        begin
            nvw_ff <= 1'b0;
            if (commit)
            begin
                pend_ff <= 1'b1;
                busy_ff <= 1'b1;
            end
            else if (pend_ff && zc_ok)
            begin
                pend_ff <= 1'b0;
                nvw_ff  <= 1'b1;
                cnt_ff  <= 32'(NV_CYCLES);
            end
            else if (busy_ff && !pend_ff)
            begin
                if (cnt_ff <= 32'h1)
                    busy_ff <= 1'b0;
                cnt_ff <= (cnt_ff == 32'h0) ? 32'h0 : cnt_ff - 32'h1;
            end
        end
    end

    assign sda_o    = tx_bit_ff;
    assign sda_oe   = sda_oe_ff;
    assign regs     = regs_ff;
    assign nv_write = nvw_ff;
    assign nv_busy  = busy_ff;

    busy_refuse_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (state_ff == dpi2c_pkg::DPI_ADDR && scl_rise && last_bit && busy_ff) |=> state_ff == dpi2c_pkg::DPI_IDLE)
        else $error("address acked while busy");
    sda_idle_a: assert property (@(posedge mclk) disable iff (!arst_n)
        state_ff == dpi2c_pkg::DPI_IDLE && $past(state_ff == dpi2c_pkg::DPI_IDLE) |-> !sda_oe_ff)
        else $error("sda driven while idle");
    stop_idle_a: assert property (@(posedge mclk) disable iff (!arst_n)
        stop_c && !start_c |=> state_ff == dpi2c_pkg::DPI_IDLE && !sda_oe_ff)
        else $error("stop not honoured");
    start_addr_a: assert property (@(posedge mclk) disable iff (!arst_n)
        start_c |=> state_ff == dpi2c_pkg::DPI_ADDR && bit_ff == 4'h0 && rd_idx_ff == 2'h0)
        else $error("start did not restart");
    vol_nocommit_a: assert property (@(posedge mclk) disable iff (!arst_n)
        stop_c && cfg_vol && !busy_ff |=> !busy_ff)
        else $error("volatile stop committed");
    zc_wait_a: assert property (@(posedge mclk) disable iff (!arst_n)
        pend_ff && cfg_zc && !zc_s && !commit |=> !nvw_ff)
        else $error("commit before zero crossing");
    disabled_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !en |=> state_ff == dpi2c_pkg::DPI_IDLE)
        else $error("active while disabled");
    rd_wrap_a: assert property (@(posedge mclk) disable iff (!arst_n)
        rack_in && !sda_s && rd_idx_ff == 2'h2 && !start_c |=> rd_idx_ff == 2'h0)
        else $error("read pointer did not wrap");
    wiper_top_a: assert property (@(posedge mclk) disable iff (!arst_n)
        $changed(regs_ff.wiper0) |-> regs_ff.wiper0[7:6] == 2'h0)
        else $error("wiper top bits set");
    sequence ack_slot_s;
        state_ff == dpi2c_pkg::DPI_AACK && scl_fall && !sda_oe_ff;
    endsequence
    sequence ack_drive_s;
        sda_oe_ff && !tx_bit_ff;
    endsequence
    ack_drive_a: assert property (@(posedge mclk) disable iff (!arst_n)
        ack_slot_s |=> ack_drive_s)
        else $error("address ack not driven");
endmodule
`default_nettype wire

// ### verification/dpi2c_master_model.sv
`default_nettype none
module dpi2c_master_model
(
    input  wire logic mclk,
    input  wire logic sda_line,
    output var  logic scl,
    output var  logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int H = 8;
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic wt();
        repeat (H) @(posedge mclk);
    endtask
    // Ends with SCL low so a repeated start never looks like a stop
    task automatic start();
        sda_pull <= 1'b0;
        wt();
        scl <= 1'b1;
        wt();
        sda_pull <= 1'b1;
        wt();
        scl <= 1'b0;
        wt();
    endtask
    task automatic stop();
        sda_pull <= 1'b1;
        wt();
        scl <= 1'b1;
        wt();
        sda_pull <= 1'b0;
        wt();
    endtask
    task automatic bitx(input logic b, output logic r);
        sda_pull <= !b;
        wt();
        scl <= 1'b1;
        wt();
        r = sda_line;
        scl <= 1'b0;
        wt();
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(d[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(1'b1, d[i]);
        bitx(!ack, r);
    endtask
endmodule
`default_nettype wire

// ### verification/dual_pot_i2c_slave_port_tb.sv
`default_nettype none
module dual_pot_i2c_slave_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NV = 400;
    localparam logic [7:0] AW = {dpi2c_pkg::ADDR_PREFIX, 3'h5, 1'b0};
    localparam logic [7:0] AR = {dpi2c_pkg::ADDR_PREFIX, 3'h5, 1'b1};
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic comm_en_n = 1'b0;
    logic zc_done = 1'b1;
    logic [2:0] straps = 3'h5;
    logic scl;
    logic sda_pull;
    logic sda_o;
    logic sda_oe;
    logic nv_write;
    logic nv_busy;
    logic ack;
    logic [7:0] d;
    int nv_cnt = 0;
    int err_count = 0;
    int n_checks = 0;
    dpi2c_pkg::dpi_regs_s regs;
    // Pull-up: line is high unless somebody pulls it
    wire logic sda_line = !(sda_pull | (sda_oe & !sda_o));
    always #2.5 mclk = ~mclk;
    always @(posedge mclk)
        if (nv_write === 1'b1)
            nv_cnt <= nv_cnt + 1;
    dpi2c_master_model i_mst (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));
    dpi2c_slave #(.NV_CYCLES(NV)) i_dut
    (
        .mclk(mclk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe(sda_oe), .comm_en_n(comm_en_n), .addr_strap_bit0(straps[0]), .addr_strap_bit1(straps[1]),
        .addr_strap_bit2(straps[2]), .zc_done(zc_done), .regs(regs), .nv_write(nv_write), .nv_busy(nv_busy)
    );
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        n_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("Error %0t: mismatch got %0h exp %0h", $time, g, e);
        end
    endtask
    task automatic t_write_multi();
        logic [7:0] wd [4];
        wd = '{8'h05, 8'h6A, 8'h86, 8'hC1};
        i_mst.start();
        i_mst.wbyte(AW, ack);
        chk(ack, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            i_mst.wbyte(wd[i], ack);
            chk(ack, 1'b1);
        end
        i_mst.stop();
        chk(regs, {8'h05, 8'h2A, 8'h86});
        chk({nv_busy, nv_cnt[0], sda_oe}, 3'h0);
    endtask
    task automatic t_read_wrap();
        i_mst.start();
        i_mst.wbyte(AW, ack);
        i_mst.start();
        i_mst.wbyte(AR, ack);
        chk(ack, 1'b1);
        i_mst.rbyte(1'b1, d);
        chk(d, 8'h05);
        i_mst.rbyte(1'b1, d);
        chk(d, 8'h2A);
        i_mst.rbyte(1'b1, d);
        chk(d, 8'h86);
        i_mst.rbyte(1'b0, d);
        chk(d, 8'h05);
        chk(sda_oe, 1'b0);
        i_mst.stop();
    endtask
    task automatic t_refused();
        i_mst.start();
        i_mst.wbyte({dpi2c_pkg::ADDR_PREFIX, 3'h2, 1'b0}, ack);
        chk(ack, 1'b0);
        i_mst.wbyte(8'h11, ack);
        chk(ack, 1'b0);
        i_mst.stop();
        // Same address is taken once the straps say so
        straps <= 3'h2;
        i_mst.start();
        i_mst.wbyte({dpi2c_pkg::ADDR_PREFIX, 3'h2, 1'b0}, ack);
        chk(ack, 1'b1);
        i_mst.stop();
        straps <= 3'h5;
        comm_en_n <= 1'b1;
        i_mst.start();
        i_mst.wbyte(AW, ack);
        chk(ack, 1'b0);
        i_mst.stop();
        comm_en_n <= 1'b0;
        i_mst.start();
        i_mst.wbyte(AW, ack);
        for (int i = 0; i < 4; i++)
            i_mst.bitx(1'b0, ack);
        i_mst.stop();
        chk(regs, {8'h05, 8'h2A, 8'h86});
    endtask
    task automatic t_nv_commit();
        zc_done <= 1'b0;
        i_mst.start();
        i_mst.wbyte(AW, ack);
        i_mst.wbyte(8'h82, ack);
        i_mst.stop();
        repeat (50) @(posedge mclk);
        chk({nv_busy, nv_cnt[1:0]}, 3'h4);
        i_mst.start();
        i_mst.wbyte(AW, ack);
        i_mst.stop();
        chk(ack, 1'b0);
        zc_done <= 1'b1;
        repeat (20) @(posedge mclk);
        chk(nv_cnt[1:0], 2'h1);
        // Acknowledge polling, bounded by a handful of tries
        for (int i = 0; i < 8 && !ack; i++)
        begin
            i_mst.start();
            i_mst.wbyte(AW, ack);
            i_mst.stop();
        end
        chk({ack, nv_busy, regs.cfg}, {2'h2, 8'h82});
    endtask
    task automatic stop_test();
        $display("Checks %0d, errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (40000) @(posedge mclk);
        err_count++;
        stop_test();
    end
    initial
    begin
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (5) @(posedge mclk);
        t_write_multi();
        t_read_wrap();
        t_refused();
        t_nv_commit();
        stop_test();
    end
endmodule
`default_nettype wire
